// >>> rtl/i6pm_mux.sv
// Purpose: function selection for the interrupt-6 multi-purpose pin
// Assumes: mode select and controls are synchronous to mclk_i
// Notes: the test-reset path is combinational so it acts without a clock
//
// Function
// - mode select high routes pin to test reset
// - normal mode: pin is interrupt, codec or gpio
// - interrupt triggers: level, rising edge, falling edge
// - codec function drives transmit shift data out
// - codec function disables primary codec transmit pin
// - gpio output level doubles as data-set-ready
// - gpio by default; gpio input after reset
// - test reset acts asynchronously on tap
// - alternate mode disconnects primary test-reset pin

`timescale 1ns/100ps

module i6pm_mux (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // mode select, high picks the alternate function
  input wire logic mode_alt_i,
  // normal-mode configuration
  input wire i6pm_pkg::i6pm_func_t pin_function_select_i,
  input wire i6pm_pkg::i6pm_trig_t irq_trig_i,
  input wire logic gpio_dir_out_i,
  input wire logic gpio_dout_i,
  // codec transmit shift register serial data
  input wire logic codec_tx_sdata_i,
  // primary test reset, active low
  input wire logic primary_trst_n_i,
  // the pin itself
  input wire logic pin_in_i,
  output logic pin_out_o,
  output logic pin_oe_o,
  // to the interrupt controller
  output logic external_irq_line_six_o,
  // gpio read-back and serial port handshake
  output logic gpio_din_o,
  output logic dsr_o,
  // primary codec transmit pin enable
  output logic codec_tx_primary_en_o,
  // test reset towards the tap controller, active low
  output logic tap_trst_n_o
);
  import i6pm_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  i6pm_state_t st_q; // registered outputs
  i6pm_state_t st_d; // next outputs
  logic pin_sync; // synchronised pin level
  logic pin_rise; // one-cycle rising edge
  logic pin_fall; // one-cycle falling edge

  // ----------------------------------------------------------------------
  // pin input synchroniser and edge detector
  // ----------------------------------------------------------------------
  i6pm_edge u_i6pm_edge (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .din_i(pin_in_i),
    .level_o(pin_sync),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // ----------------------------------------------------------------------
  // next-state logic for the normal functions
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.pin_out = I6PM_OUT_RST;
    st_d.pin_oe = I6PM_OE_RST;
    st_d.irq = I6PM_IRQ_RST;
    st_d.gpio_din = pin_sync;
    st_d.dsr = st_q.dsr;
    st_d.codec_pri_en = I6PM_PRI_EN_RST;
    if (mode_alt_i) begin
      // alternate mode: pin is a pure input for test reset
      st_d.pin_oe = I6PM_OE_RST;
    end else begin
      case (pin_function_select_i)
        I6PM_FN_IRQ: begin
          // pin stays an input and feeds the interrupt request
          case (irq_trig_i)
            I6PM_TRIG_RISE: begin
              st_d.irq = pin_rise;
            end
            I6PM_TRIG_FALL: begin
              st_d.irq = pin_fall;
            end
            default: begin
              st_d.irq = (pin_sync == I6PM_IRQ_ACTIVE_LVL);
            end
          endcase
        end
        I6PM_FN_CODEC: begin
          // codec transmit data leaves here, primary pin goes quiet
          st_d.pin_oe = 1'h1;
          st_d.pin_out = codec_tx_sdata_i;
          st_d.codec_pri_en = 1'h0;
        end
        default: begin
          // gpio; direction from software, input after reset
          st_d.pin_oe = gpio_dir_out_i;
          if (gpio_dir_out_i) begin
            st_d.pin_out = gpio_dout_i;
            st_d.dsr = gpio_dout_i;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // output registers; reset leaves the pin a gpio input
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= '{pin_out: I6PM_OUT_RST, pin_oe: I6PM_OE_RST, irq: I6PM_IRQ_RST,
                gpio_din: I6PM_PIN_IDLE, dsr: I6PM_OUT_RST,
                codec_pri_en: I6PM_PRI_EN_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_out_o = st_q.pin_out;
  assign pin_oe_o = st_q.pin_oe;
  assign external_irq_line_six_o = st_q.irq;
  assign gpio_din_o = st_q.gpio_din;
  assign dsr_o = st_q.dsr;
  assign codec_tx_primary_en_o = st_q.codec_pri_en;

  // ----------------------------------------------------------------------
  // test-reset routing, no clock in the path so reset is asynchronous
  // ----------------------------------------------------------------------
  // a glitch-free switch is the outside agent's job, none is added here
  always_comb begin
    if (mode_alt_i) begin
      tap_trst_n_o = pin_in_i;
    end else begin
      tap_trst_n_o = primary_trst_n_i;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_alt_pin_input: assert property (
    mode_alt_i |=> !pin_oe_o && !external_irq_line_six_o
  ) else $error("pin driven or irq raised in alternate mode");

  a_irq_no_drive: assert property (
    (!mode_alt_i && pin_function_select_i == I6PM_FN_IRQ) |=> !pin_oe_o
  ) else $error("pin driven while used as interrupt input");

  a_level_irq: assert property (
    (!mode_alt_i && pin_function_select_i == I6PM_FN_IRQ &&
     irq_trig_i == I6PM_TRIG_LEVEL && !pin_in_i)[*3]
    |=> external_irq_line_six_o
  ) else $error("level interrupt missing while pin held low");

  a_rise_irq: assert property (
    (!mode_alt_i && pin_function_select_i == I6PM_FN_IRQ &&
     irq_trig_i == I6PM_TRIG_RISE && pin_rise) |=> external_irq_line_six_o
  ) else $error("rising edge gave no interrupt");

  a_fall_irq: assert property (
    (!mode_alt_i && pin_function_select_i == I6PM_FN_IRQ &&
     irq_trig_i == I6PM_TRIG_FALL && pin_fall) |=> external_irq_line_six_o
  ) else $error("falling edge gave no interrupt");

  // only the two edge codes pulse; the spare code behaves as level
  a_edge_single: assert property (
    (external_irq_line_six_o &&
     (irq_trig_i == I6PM_TRIG_RISE || irq_trig_i == I6PM_TRIG_FALL) &&
     $past(irq_trig_i) == irq_trig_i && irq_trig_i == $past(irq_trig_i, 2))
    |=> !external_irq_line_six_o
  ) else $error("edge interrupt lasted more than one cycle");

  a_codec_drive: assert property (
    (!mode_alt_i && pin_function_select_i == I6PM_FN_CODEC)
    |=> pin_oe_o && pin_out_o == $past(codec_tx_sdata_i)
  ) else $error("codec transmit data not driven on pin");

  a_codec_primary_off: assert property (
    pin_oe_o && !codec_tx_primary_en_o |-> $past(pin_function_select_i) == I6PM_FN_CODEC
  ) else $error("primary codec pin off outside codec function");

  a_dsr_follow: assert property (
    (!mode_alt_i && pin_function_select_i == I6PM_FN_GPIO && gpio_dir_out_i)
    |=> dsr_o == pin_out_o && pin_oe_o && dsr_o == $past(gpio_dout_i)
  ) else $error("data-set-ready does not follow gpio output");

  a_reset_gpi: assert property (
    $fell(rst_i) |-> !pin_oe_o && codec_tx_primary_en_o && !external_irq_line_six_o
  ) else $error("pin not a gpio input after reset");

  a_trst_async: assert property (
    (mode_alt_i && !pin_in_i) |-> !tap_trst_n_o
  ) else $error("test reset not passed through at once");

  a_primary_cut: assert property (
    (mode_alt_i && pin_in_i && !primary_trst_n_i) |-> tap_trst_n_o
  ) else $error("primary test reset still reaches tap");

  c_codec_use: cover property (
    !mode_alt_i && pin_function_select_i == I6PM_FN_CODEC ##1 pin_oe_o
  );

  c_fall_irq: cover property (
    irq_trig_i == I6PM_TRIG_FALL && pin_fall ##1 external_irq_line_six_o
  );

  c_alt_trst: cover property (
    mode_alt_i && !tap_trst_n_o
  );

  c_dsr_high: cover property (
    $rose(dsr_o)
  );

endmodule

// >>> rtl/i6pm_pkg.sv
// Purpose: shared types and constants for the interrupt-6 pin function mux
// Assumes: one device clock, synchronous active-high reset
// Notes: no register map; every control bit is a plain port

package i6pm_pkg;

  // ----------------------------------------------------------------------
  // function and trigger selections
  // ----------------------------------------------------------------------
  // normal-mode pin function; the unused code falls back to gpio
  typedef enum logic [1:0] {
    I6PM_FN_GPIO,
    I6PM_FN_IRQ,
    I6PM_FN_CODEC
  } i6pm_func_t;

  // interrupt trigger mode; the unused code falls back to level
  typedef enum logic [1:0] {
    I6PM_TRIG_LEVEL,
    I6PM_TRIG_RISE,
    I6PM_TRIG_FALL
  } i6pm_trig_t;

  // ----------------------------------------------------------------------
  // reset and idle values
  // ----------------------------------------------------------------------
  localparam logic I6PM_PIN_IDLE = 1'h1; // pin is pulled up when undriven
  localparam logic I6PM_OE_RST = 1'h0; // gpio input after reset
  localparam logic I6PM_OUT_RST = 1'h0; // output data before first drive
  localparam logic I6PM_IRQ_RST = 1'h0; // no request after reset
  localparam logic I6PM_PRI_EN_RST = 1'h1; // primary codec pin enabled
  localparam logic I6PM_IRQ_ACTIVE_LVL = 1'h0; // level mode asserts on low

  // ----------------------------------------------------------------------
  // state records
  // ----------------------------------------------------------------------
  // synchroniser and edge history of the pin input
  typedef struct packed {
    logic meta; // first stage, read only by the second
    logic sync; // synchronised pin level
    logic prev; // synchronised level one cycle earlier
  } i6pm_sync_t;

  // registered outputs of the mux
  typedef struct packed {
    logic pin_out; // level driven onto the pin
    logic pin_oe; // pin output enable
    logic irq; // interrupt request to the controller
    logic gpio_din; // gpio input value
    logic dsr; // data-set-ready towards the serial port
    logic codec_pri_en; // primary codec transmit pin enable
  } i6pm_state_t;

endpackage

// >>> rtl/i6pm_edge.sv
// Purpose: synchronise the pin input and flag its edges
// Assumes: pin input may change at any time
// Notes: rise and fall are single-cycle pulses from registered history

`timescale 1ns/100ps

module i6pm_edge (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // raw pin level
  input wire logic din_i,
  // synchronised level and edge pulses
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  import i6pm_pkg::*;

  i6pm_sync_t st_q; // registered history
  i6pm_sync_t st_d; // next history

  // ----------------------------------------------------------------------
  // next state: shift the pin level through two stages and a history bit
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.meta = din_i;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
  end

  // idle level matches the pull-up so reset gives no false edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= '{meta: I6PM_PIN_IDLE, sync: I6PM_PIN_IDLE, prev: I6PM_PIN_IDLE};
    end else begin
      st_q <= st_d;
    end
  end

  // edges are seen only on the synchronised stages
  assign level_o = st_q.sync;
  assign rise_o = st_q.sync & ~st_q.prev;
  assign fall_o = ~st_q.sync & st_q.prev;

endmodule

// >>> test/i6pm_board.sv
// Purpose: board side of the multi-purpose pin, an outside driver plus pull-up
// Assumes: the outside driver only drives while the device is not driving
// Notes: an undriven pin floats to the pull-up level

`timescale 1ns/100ps

module i6pm_board (
  // device side of the pin
  input wire logic pin_out_i,
  input wire logic pin_oe_i,
  // outside driver, controlled by the bench
  input wire logic drv_en_i,
  input wire logic drv_val_i,
  // resolved pin level
  output logic pin_level_o
);
  import i6pm_pkg::*;
  // --------------------------------------------------------------------
  // wire resolution
  // --------------------------------------------------------------------
  // device wins, then the outside driver, else the pull-up
  assign pin_level_o = pin_oe_i ? pin_out_i : (drv_en_i ? drv_val_i : I6PM_PIN_IDLE);
endmodule

// >>> test/interrupt6_pin_function_mux_bench.sv
// Purpose: self-checking bench for the interrupt-6 pin function mux
// Assumes: inputs change at the falling edge, outputs are read there
// Notes: pin level comes from the board model

`timescale 1ns/100ps

module interrupt6_pin_function_mux_bench;
  import i6pm_pkg::*;
  // --------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------
  logic mclk_i = 1'h0, rst_i = 1'h1, mode_alt_i = 1'h0, dir_out = 1'h0, dout = 1'h0;
  logic sdata = 1'h0, prim_trst_n = 1'h1, drv_en = 1'h0, drv_val = 1'h1;
  i6pm_func_t sel = I6PM_FN_GPIO;
  i6pm_trig_t trig = I6PM_TRIG_LEVEL;
  logic pin_lvl, pin_out, pin_oe, irq, gpio_din, dsr, pri_en, tap_n;
  int err_count = 0, checks_done = 0, c;

  // 25 MHz clock
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  i6pm_mux u_i6pm_mux (.mclk_i(mclk_i), .rst_i(rst_i), .mode_alt_i(mode_alt_i),
    .pin_function_select_i(sel), .irq_trig_i(trig), .gpio_dir_out_i(dir_out),
    .gpio_dout_i(dout), .codec_tx_sdata_i(sdata), .primary_trst_n_i(prim_trst_n),
    .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .external_irq_line_six_o(irq), .gpio_din_o(gpio_din), .dsr_o(dsr),
    .codec_tx_primary_en_o(pri_en), .tap_trst_n_o(tap_n));
  i6pm_board u_i6pm_board (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .drv_en_i(drv_en),
    .drv_val_i(drv_val), .pin_level_o(pin_lvl));

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // compare and count
  task automatic check(input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask
  // wait n falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // outside driver puts a level on the pin
  task automatic drive(input logic v);
    drv_en = 1'h1;
    drv_val = v;
  endtask
  // count request cycles over a fixed window
  task automatic count_irq(input int n);
    c = 0;
    repeat (n) begin
      @(negedge mclk_i);
      c += (irq === 1'h1);
    end
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  // reset leaves the pin a gpio input with no request
  task automatic reset_defaults;
    tick(2);
    check(pin_oe, 1'h0);
    check(pin_out, 1'h0);
    check(irq, 1'h0);
    check(pri_en, 1'h1);
    rst_i = 1'h0;
    tick(4);
    check(gpio_din, 1'h1);
  endtask
  // gpio output drives pin and doubles as data-set-ready
  task automatic gpio_out;
    sel = I6PM_FN_GPIO;
    dir_out = 1'h1;
    dout = 1'h1;
    tick(1);
    check(pin_oe, 1'h1);
    check(pin_out, 1'h1);
    check(dsr, 1'h1);
    dout = 1'h0;
    tick(1);
    check(dsr, 1'h0);
    dout = 1'h1;
    tick(1);
    dir_out = 1'h0;
    dout = 1'h0;
    tick(1);
    check(pin_oe, 1'h0);
    check(dsr, 1'h1);
  endtask
  // codec data on the pin, primary pin off, reserved code back to gpio
  task automatic codec_out;
    sel = I6PM_FN_CODEC;
    sdata = 1'h1;
    tick(1);
    sdata = 1'h0;
    check(pin_oe, 1'h1);
    check(pin_out, 1'h1);
    check(pri_en, 1'h0);
    tick(1);
    check(pin_out, 1'h0);
    sel = i6pm_func_t'(2'h3);
    tick(1);
    check(pri_en, 1'h1);
    check(pin_oe, 1'h0);
  endtask
  // reset in mid-run drops the codec function back to a gpio input
  task automatic mid_reset;
    sel = I6PM_FN_CODEC;
    tick(1);
    check(pri_en, 1'h0);
    rst_i = 1'h1;
    tick(2);
    check(pin_oe, 1'h0);
    check(pri_en, 1'h1);
    rst_i = 1'h0;
    sel = I6PM_FN_GPIO;
    tick(2);
    check(pin_oe, 1'h0);
    check(irq, 1'h0);
  endtask
  // both edge trigger modes, one request per matching edge and none on the other, then level mode
  task automatic irq_modes;
    sel = I6PM_FN_IRQ;
    for (int t = 1; t <= 2; t++) begin
      trig = i6pm_trig_t'(t);
      drive(1'h0);
      tick(6);
      drive(1'h1);
      count_irq(8);
      check(c == 1, t == 1);
      drive(1'h0);
      count_irq(8);
      check(c == 1, t == 2);
    end
    trig = I6PM_TRIG_LEVEL;
    tick(5);
    check(irq, 1'h1);
    // the spare trigger code behaves as level
    trig = i6pm_trig_t'(2'h3);
    tick(2);
    check(irq, 1'h1);
    drive(1'h1);
    tick(5);
    check(irq, 1'h0);
    sel = I6PM_FN_GPIO;
    drive(1'h0);
    tick(5);
    check(irq, 1'h0);
    check(gpio_din, 1'h0);
  endtask
  // alternate mode routes the pin to test reset
  task automatic alt_mode;
    sel = I6PM_FN_IRQ;
    drive(1'h1);
    prim_trst_n = 1'h1;
    tick(4);
    mode_alt_i = 1'h1;
    tick(1);
    prim_trst_n = 1'h0;
    #1 check(tap_n, 1'h1);
    tick(1);
    drive(1'h0);
    #1 check(tap_n, 1'h0);
    tick(5);
    check(irq, 1'h0);
    check(pin_oe, 1'h0);
    // test reset and primary pin inactive well before switching back
    drive(1'h1);
    prim_trst_n = 1'h1;
    tick(3);
    mode_alt_i = 1'h0;
    #1 check(tap_n, 1'h1);
    tick(1);
    prim_trst_n = 1'h0;
    #1 check(tap_n, 1'h0);
    tick(1);
    check(irq, 1'h0);
  endtask

  // --------------------------------------------------------------------
  // closing report
  // --------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    reset_defaults();
    gpio_out();
    codec_out();
    mid_reset();
    irq_modes();
    alt_mode();
    print_verdict();
  end
endmodule
